// ---- verilog/wdc_pkg.sv ----
// package for the watchdog channel 1 control/status block
package wdc_pkg;
    localparam int unsigned CTRL_W = 8;
    localparam int unsigned CNT_W = 8;
    localparam logic [2:0] BIT_OVF = 3'h7;
    localparam logic [2:0] BIT_MODE = 3'h6;
    localparam logic [2:0] BIT_RUN = 3'h5;
    localparam logic [2:0] BIT_PSS = 3'h4;
    localparam logic [2:0] BIT_RSTNMI = 3'h3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam int unsigned MAIN_PRE_W = 17;
    localparam int unsigned SUB_PRE_W = 8;
    localparam int unsigned REQ_CYCLES = 516;
    localparam logic [9:0] REQ_LEN = 10'(REQ_CYCLES);

    typedef enum logic {
        WDC_MODE_INTERVAL,
        WDC_MODE_WATCHDOG
    } wdc_mode_type;

    // register access strobes from the cpu side
    typedef struct packed {
        logic ctrl_rd;
        logic ctrl_wr;
        logic cnt_wr;
        logic [7:0] wdata;
    } wdc_acc_type;

    // divider tap of the main prescaler per code: /2,/64,/128,/512,/2048,/8192,/32768,/131072
    function automatic logic [4:0] wdc_main_tap(input logic [2:0] code);
        case (code)
            3'h0: wdc_main_tap = 5'h00;
            3'h1: wdc_main_tap = 5'h05;
            3'h2: wdc_main_tap = 5'h06;
            3'h3: wdc_main_tap = 5'h08;
            3'h4: wdc_main_tap = 5'h0A;
            3'h5: wdc_main_tap = 5'h0C;
            3'h6: wdc_main_tap = 5'h0E;
            default: wdc_main_tap = 5'h10;
        endcase
    endfunction : wdc_main_tap
endpackage : wdc_pkg

// ---- verilog/wdc_prescaler.sv ----
// free-running prescaler giving a one-cycle tick at a chosen power-of-two tap
`timescale 1ns/1ps
`default_nettype none
module wdc_prescaler #(
    parameter int unsigned WIDTH = 17
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_step,
    input wire logic [4:0] i_tap,
    output logic o_tick
);
    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;
    logic tick_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        tick_nxt = 1'b0;
        if (i_step) begin
            cnt_nxt = cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};
            // tick when all bits up to the tap roll over: period 2^(tap+1)
            tick_nxt = &(cnt_r | ~((({{(WIDTH-1){1'b0}}, 1'b1}) << (i_tap + 5'h01))
                - {{(WIDTH-1){1'b0}}, 1'b1}));
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cnt_r <= '0;
            o_tick <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            o_tick <= tick_nxt;
        end
    end
endmodule : wdc_prescaler
`default_nettype wire

// ---- verilog/wdc_ctrl.sv ----
// watchdog channel 1 counter, control/status register and overflow requests
// Contract
// - overflow flag sets when counter wraps from FF to 00.
// - internal reset from watchdog overflow clears the overflow flag automatically.
// - flag clears only on write 0 after reading it as 1, or on internal reset from watchdog overflow.
// - writing 1 to the overflow flag leaves it unchanged.
// - bit 6 selects interval (0) or watchdog (1) mode, reset 0.
// - run bit 5 set starts counting on selected clock.
// - clearing run bit stops counter and forces it to zero.
// - bit 4 selects main prescaler (0) or sub-clock prescaler (1).
// - bit 3 selects NMI (0) or internal reset (1) on watchdog overflow.
// - main codes select clock divided by 2 through 131072.
// - sub codes select sub-clock divided by 2 through 256.
// - overflow period is 256 selected ticks starting from zero.
// - counter is an 8-bit software readable and writable up-counter.
// - interval mode raises interval interrupt when overflow sets the flag.
// - watchdog overflow asserts reset or NMI request for 516 clocks.
`timescale 1ns/1ps
`default_nettype none
module wdc_ctrl (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire wdc_pkg::wdc_acc_type i_acc,
    input wire logic i_sub_clk,
    output logic [7:0] o_ctrl_rdata,
    output logic [7:0] o_cnt_rdata,
    output logic o_interval_irq,
    output logic o_nmi_req,
    output logic o_reset_req
);
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic armed_r;
    logic armed_nxt;
    logic [9:0] req_cnt_r;
    logic [9:0] req_cnt_nxt;
    logic req_rst_r;
    logic req_rst_nxt;
    logic irq_r;
    logic irq_nxt;
    logic sub_s1_r;
    logic sub_s2_r;
    logic sub_s3_r;
    logic sub_rise;
    logic main_tick;
    logic sub_tick;
    logic sel_tick;
    logic ovf_evt;
    logic run;
    logic watchdog;

    assign run = ctrl_r[wdc_pkg::BIT_RUN];
    assign watchdog = (ctrl_r[wdc_pkg::BIT_MODE] == wdc_pkg::WDC_MODE_WATCHDOG);

    // sub clock is slow; sampled as a level then edge-detected past the second stage
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            sub_s1_r <= 1'b0;
            sub_s2_r <= 1'b0;
            sub_s3_r <= 1'b0;
        end else begin
            sub_s1_r <= i_sub_clk;
            sub_s2_r <= sub_s1_r;
            sub_s3_r <= sub_s2_r;
        end
    end
    assign sub_rise = sub_s2_r & ~sub_s3_r;

    wdc_prescaler #(.WIDTH(wdc_pkg::MAIN_PRE_W)) u_main_pre (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_step(1'b1),
        .i_tap(wdc_pkg::wdc_main_tap(ctrl_r[2:0])),
        .o_tick(main_tick)
    );

    wdc_prescaler #(.WIDTH(wdc_pkg::SUB_PRE_W)) u_sub_pre (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_step(sub_rise),
        .i_tap({2'b00, ctrl_r[2:0]}),
        .o_tick(sub_tick)
    );

    assign sel_tick = ctrl_r[wdc_pkg::BIT_PSS] ? sub_tick : main_tick;
    assign ovf_evt = run && sel_tick && !i_acc.cnt_wr && (cnt_r == wdc_pkg::CNT_MAX);

    always_comb begin
        cnt_nxt = cnt_r;
        if (i_acc.cnt_wr) begin
            cnt_nxt = i_acc.wdata;
        end else if (run && sel_tick) begin
            cnt_nxt = cnt_r + 8'h01;
        end
        if (!run || req_rst_r) begin
            cnt_nxt = wdc_pkg::CNT_RESET;
        end
    end

    always_comb begin
        ctrl_nxt = ctrl_r;
        armed_nxt = armed_r;
        if (i_acc.ctrl_rd && ctrl_r[wdc_pkg::BIT_OVF]) begin
            armed_nxt = 1'b1;
        end
        if (i_acc.ctrl_wr) begin
            ctrl_nxt[6:0] = i_acc.wdata[6:0];
            if (armed_r && !i_acc.wdata[wdc_pkg::BIT_OVF]) begin
                ctrl_nxt[wdc_pkg::BIT_OVF] = 1'b0;
                armed_nxt = 1'b0;
            end
        end
        // a new overflow wins over a clear in the same cycle
        if (ovf_evt) begin
            ctrl_nxt[wdc_pkg::BIT_OVF] = 1'b1;
        end
        // internal reset: flag and control cleared as the counter block resets
        if (req_rst_r && req_cnt_r == 10'h001) begin
            ctrl_nxt = wdc_pkg::CTRL_RESET;
            armed_nxt = 1'b0;
        end
    end

    always_comb begin
        req_cnt_nxt = req_cnt_r;
        req_rst_nxt = req_rst_r;
        irq_nxt = ovf_evt && !watchdog;
        if (req_cnt_r != 10'h000) begin
            req_cnt_nxt = req_cnt_r - 10'h001;
        end else begin
            req_rst_nxt = 1'b0;
        end
        if (ovf_evt && watchdog && req_cnt_r == 10'h000) begin
            req_cnt_nxt = wdc_pkg::REQ_LEN;
            req_rst_nxt = ctrl_r[wdc_pkg::BIT_RSTNMI];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ctrl_r <= wdc_pkg::CTRL_RESET;
            cnt_r <= wdc_pkg::CNT_RESET;
            armed_r <= 1'b0;
            req_cnt_r <= 10'h000;
            req_rst_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            cnt_r <= cnt_nxt;
            armed_r <= armed_nxt;
            req_cnt_r <= req_cnt_nxt;
            req_rst_r <= req_rst_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign o_ctrl_rdata = ctrl_r;
    assign o_cnt_rdata = cnt_r;
    assign o_interval_irq = irq_r;
    assign o_reset_req = (req_cnt_r != 10'h000) && req_rst_r;
    assign o_nmi_req = (req_cnt_r != 10'h000) && !req_rst_r;
endmodule : wdc_ctrl
`default_nettype wire

// ---- test/wdc_ctrl_assertions.sv ----
// checker for the watchdog channel 1 control block
`timescale 1ns/1ps
`default_nettype none
module wdc_ctrl_assertions (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire wdc_pkg::wdc_acc_type i_acc,
    input wire logic i_sub_clk,
    input wire logic [7:0] o_ctrl_rdata,
    input wire logic [7:0] o_cnt_rdata,
    input wire logic o_interval_irq,
    input wire logic o_nmi_req,
    input wire logic o_reset_req
);
    logic [9:0] len_r;
    logic [9:0] len_nxt;
    wire logic req = o_nmi_req || o_reset_req;
    always_comb begin
        len_nxt = req ? len_r + 10'h001 : 10'h000;
    end
    always_ff @(posedge i_core_clk) begin
        len_r <= i_rst ? 10'h000 : len_nxt;
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    a_ovf_on_wrap: assert property (
        o_ctrl_rdata[5] && o_cnt_rdata == 8'hFF && !i_acc.cnt_wr && !i_acc.ctrl_wr
        ##1 o_cnt_rdata == 8'h00 |-> o_ctrl_rdata[7]) else $error("wrap left flag clear");
    a_flag_write_one: assert property (
        i_acc.ctrl_wr && i_acc.wdata[7] && !o_reset_req && o_cnt_rdata != 8'hFF
        |=> $stable(o_ctrl_rdata[7])) else $error("flag moved on write of one");
    a_flag_clear_cause: assert property (
        $fell(o_ctrl_rdata[7]) |-> $past(i_acc.ctrl_wr) && !$past(i_acc.wdata[7])
        || $past(o_reset_req) || $past(o_reset_req, 2)) else $error("flag cleared alone");
    a_stop_zero: assert property (
        !o_ctrl_rdata[5] [*2] |-> o_cnt_rdata == 8'h00) else $error("stopped counter not zero");
    a_count_step: assert property (
        o_ctrl_rdata[5] && !i_acc.cnt_wr && !i_acc.ctrl_wr |=> o_cnt_rdata == $past(o_cnt_rdata)
        || o_cnt_rdata == $past(o_cnt_rdata) + 8'h01) else $error("counter jumped");
    a_irq_with_flag: assert property (
        o_interval_irq |-> o_ctrl_rdata[7] && !o_ctrl_rdata[6] && $past(o_cnt_rdata) == 8'hFF)
        else $error("stray interval interrupt");
    a_req_length: assert property (
        $fell(req) |-> len_r == 10'h204) else $error("request length wrong");
    a_rst_clears: assert property (
        $fell(o_reset_req) |-> ##[0:1] o_ctrl_rdata == 8'h00) else $error("control not cleared");
    c_irq: cover property (o_interval_irq);
    c_nmi: cover property ($rose(o_nmi_req));
    c_rst: cover property ($rose(o_reset_req));
endmodule : wdc_ctrl_assertions
bind wdc_ctrl wdc_ctrl_assertions i_chk (.i_core_clk, .i_rst, .i_acc, .i_sub_clk,
    .o_ctrl_rdata, .o_cnt_rdata, .o_interval_irq, .o_nmi_req, .o_reset_req);
`default_nettype wire

// ---- test/wdc_ctrl_tb.sv ----
// testbench for the watchdog channel 1 control block
`timescale 1ns/1ps
`default_nettype none
module wdc_ctrl_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sub = 1'b0;
    logic [1:0] sdiv = 2'h0;
    logic [7:0] prev;
    logic [7:0] ctrl;
    logic [7:0] cnt;
    logic irq;
    logic nmi;
    logic rreq;
    wdc_pkg::wdc_acc_type acc = '0;
    int fails = 0;
    int n_tests = 0;
    int n;
    int mdiv[6] = '{2, 64, 128, 512, 2048, 8192};
    wire logic [5:0] ev = {!rreq, !nmi, rreq, nmi, irq, cnt != prev};
    always #10 clk = !clk;
    // sub-clock locked to the core clock, period six cycles, so periods are exact
    always @(posedge clk) begin
        prev <= cnt;
        sdiv <= (sdiv == 2'h2) ? 2'h0 : sdiv + 2'h1;
        if (sdiv == 2'h2)
            sub <= !sub;
    end
    wdc_ctrl i_dut (.i_core_clk(clk), .i_rst(rst), .i_acc(acc), .i_sub_clk(sub),
        .o_ctrl_rdata(ctrl), .o_cnt_rdata(cnt), .o_interval_irq(irq), .o_nmi_req(nmi),
        .o_reset_req(rreq));
    task automatic end_of_test;
        if (fails == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %0h want %0h", $time, got, exp);
        end
    endtask : chk
    // k is {read, control write, counter write}
    task automatic acc_op(input logic [2:0] k, input logic [7:0] d);
        @(posedge clk);
        acc <= {k, d};
        @(posedge clk);
        acc <= '0;
        #1;
    endtask : acc_op
    task automatic wt(input int s);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
            if (n > 70000) begin
                fails++;
                end_of_test;
            end
        end while (!ev[s]);
    endtask : wt
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({ctrl, cnt}, 16'h0000);
        for (int c = 0; c < 14; c++) begin
            acc_op(3'h2, c < 6 ? 8'h20 | 8'(c) : 8'h30 | 8'(c - 6));
            wt(0);
            wt(0);
            chk(n, c < 6 ? mdiv[c] : 12 << (c - 6));
        end
        acc_op(3'h2, 8'h20);
        acc_op(3'h1, 8'h5A);
        chk(cnt, 8'h5A);
        acc_op(3'h1, 8'hFE);
        wt(1);
        chk(ctrl, 8'hA0);
        acc_op(3'h2, 8'hA0);
        acc_op(3'h2, 8'h20);
        chk(ctrl[7], 1'b1);
        acc_op(3'h4, 8'h00);
        acc_op(3'h2, 8'h20);
        chk(ctrl, 8'h20);
        acc_op(3'h2, 8'h60);
        chk(ctrl, 8'h60);
        acc_op(3'h1, 8'hFE);
        wt(2);
        wt(4);
        chk({n, rreq, ctrl}, {32'h204, 1'b0, 8'hE0});
        acc_op(3'h4, 8'h00);
        acc_op(3'h2, 8'h68);
        acc_op(3'h1, 8'hFE);
        wt(3);
        wt(5);
        chk({n, nmi}, {32'h204, 1'b0});
        @(posedge clk);
        #1;
        chk(ctrl, 8'h00);
        acc_op(3'h2, 8'h20);
        acc_op(3'h1, 8'h40);
        acc_op(3'h2, 8'h00);
        acc_op(3'h1, 8'h33);
        chk(cnt, 8'h00);
        end_of_test;
    end
endmodule : wdc_ctrl_tb
`default_nettype wire
